// ===== src/mca_pkg.sv
package mca_pkg;

  // ****************************************
  // field layout of the control byte and entry word, plus draw constants
  // ****************************************
  localparam int CTRL_CH_HI = 7;
  localparam int CTRL_CH_LO = 5;
  localparam int CTRL_RESULT_BIT = 4;
  localparam int CTRL_GRANT_BIT = 3;
  localparam int REF_BITS = 13;
  localparam int ENTRY_STACK_BIT = 15;
  localparam int SPREAD_BITS = 14;
  localparam int LFSR_BITS = 16;
  localparam logic [LFSR_BITS-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_BITS-1:0] LFSR_TAPS = 16'hB400;

  // ****************************************
  // feedback codes
  // ****************************************
  localparam logic [7:0] CODE_IDLE = 8'hFF;
  localparam logic [7:0] CODE_SUCCESS = 8'hFE;
  localparam logic [7:0] CID_ENTRY = 8'h00;
  localparam logic [1:0] MINISLOTS_PER_GROUP = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int GRANT_TIMEOUT_US = 100;
  localparam int GRANT_TIMEOUT_CYC = GRANT_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_REF_HI = 4'h1,
    ST_REF_LO = 4'h2,
    ST_FB_CNT = 4'h3,
    ST_FB_OFS = 4'h4,
    ST_FB_CODE = 4'h5,
    ST_EN_HI = 4'h6,
    ST_EN_LO = 4'h7,
    ST_AL_CNT = 4'h8,
    ST_AL_OFS = 4'h9,
    ST_AL_CN = 4'hA
  } mca_state_t;

  typedef struct packed {
    logic start;
    logic valid;
    logic [7:0] data;
  } mca_byte_t;

  typedef struct packed {
    logic valid;
    logic [REF_BITS-1:0] slot;
    logic [1:0] minislot;
  } mca_tx_t;

  typedef struct packed {
    logic valid;
    logic [15:0] tag;
    logic [7:0] remaining;
  } mca_status_t;

endpackage

// ===== src/mca_lfsr.sv
`timescale 1ns/1ps
module mca_lfsr #(
  parameter int W = 16,
  parameter logic [W-1:0] SEED = '1,
  parameter logic [W-1:0] TAPS = '1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // state
  output logic [W-1:0] value
);

  logic [W-1:0] lfsr_d;
  logic [W-1:0] lfsr_q;

  // galois form, free running so draws depend on arrival time too
  always_comb begin
    lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ TAPS) : (lfsr_q >> 1);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_q <= SEED;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign value = lfsr_q;

endmodule

// ===== src/mca_top.sv
`timescale 1ns/1ps
module mca_top #(
  parameter int GRANT_TIMEOUT_CYCLES = mca_pkg::GRANT_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // downstream minislot control byte stream
  input wire mca_pkg::mca_byte_t ds_byte,
  // configuration
  input wire logic [2:0] my_channel,
  input wire logic [7:0] own_cid,
  // request side
  input wire logic req_new,
  input wire logic grant_pending,
  input wire logic grant_seen,
  input wire logic [15:0] connection_tag,
  input wire logic [7:0] remaining_slots,
  // outputs
  output mca_pkg::mca_tx_t tx_req,
  output logic contending,
  output logic contend_done,
  output logic collision_seen,
  output logic [7:0] collision_cid,
  output mca_pkg::mca_status_t status_req
);

  // ****************************************
  // parser state
  // ****************************************
  mca_pkg::mca_state_t state_q, state_d;
  logic mine_q, mine_d;
  logic res_en_q, res_en_d;
  logic grant_en_q, grant_en_d;
  logic [mca_pkg::REF_BITS-1:0] ref_q, ref_d;
  logic [7:0] cnt_q, cnt_d;
  logic [mca_pkg::REF_BITS-1:0] grp_slot_q, grp_slot_d;
  logic [1:0] ms_idx_q, ms_idx_d;
  logic stack_q, stack_d;
  logic [mca_pkg::SPREAD_BITS-1:0] spread_hi_q, spread_hi_d;

  // ****************************************
  // contention state
  // ****************************************
  logic pending_q, pending_d;
  logic entered_q, entered_d;
  logic used_q, used_d;
  logic [mca_pkg::REF_BITS-1:0] used_slot_q, used_slot_d;
  logic [1:0] used_ms_q, used_ms_d;
  logic [mca_pkg::SPREAD_BITS-1:0] draw_q, draw_d;
  logic [14:0] zero_idx_q, zero_idx_d;
  mca_pkg::mca_tx_t tx_q, tx_d;
  logic done_q, done_d;
  logic col_q, col_d;
  logic [7:0] col_cid_q, col_cid_d;

  // ****************************************
  // status request state
  // ****************************************
  logic [31:0] tmo_q, tmo_d;
  mca_pkg::mca_status_t stat_q, stat_d;

  logic [mca_pkg::LFSR_BITS-1:0] rnd;
  logic [28:0] scaled;
  logic [1:0] rnd_ms;
  logic [mca_pkg::REF_BITS-1:0] ofs_slot;
  logic [14:0] draw_rel;

  mca_lfsr #(
    .W(mca_pkg::LFSR_BITS),
    .SEED(mca_pkg::LFSR_SEED),
    .TAPS(mca_pkg::LFSR_TAPS)
  ) u_lfsr (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .value(rnd)
  );

  assign scaled = 29'(rnd[mca_pkg::SPREAD_BITS-1:0]) * 29'({spread_hi_q[13:8], ds_byte.data})
                  + 29'(rnd[mca_pkg::SPREAD_BITS-1:0]);
  assign rnd_ms = (rnd[15:14] == 2'h3) ? 2'h0 : rnd[15:14];
  // offset added to the 13-bit reference
  assign ofs_slot = ref_q + mca_pkg::REF_BITS'(ds_byte.data);
  assign draw_rel = 15'(draw_q) - zero_idx_q;

  always_comb begin
    state_d = state_q;
    mine_d = mine_q;
    res_en_d = res_en_q;
    grant_en_d = grant_en_q;
    ref_d = ref_q;
    cnt_d = cnt_q;
    grp_slot_d = grp_slot_q;
    ms_idx_d = ms_idx_q;
    stack_d = stack_q;
    spread_hi_d = spread_hi_q;
    pending_d = pending_q | req_new;
    entered_d = entered_q;
    used_d = used_q;
    used_slot_d = used_slot_q;
    used_ms_d = used_ms_q;
    draw_d = draw_q;
    zero_idx_d = zero_idx_q;
    tx_d = '0;
    done_d = 1'b0;
    col_d = 1'b0;
    col_cid_d = col_cid_q;
    if (ds_byte.valid && ds_byte.start) begin
      // only our upstream channel is acted on
      mine_d = (ds_byte.data[mca_pkg::CTRL_CH_HI:mca_pkg::CTRL_CH_LO] == my_channel);
      res_en_d = ds_byte.data[mca_pkg::CTRL_RESULT_BIT];
      grant_en_d = ds_byte.data[mca_pkg::CTRL_GRANT_BIT];
      if (ds_byte.data[mca_pkg::CTRL_RESULT_BIT] || ds_byte.data[mca_pkg::CTRL_GRANT_BIT]) begin
        state_d = mca_pkg::ST_REF_HI;
      end else begin
        state_d = mca_pkg::ST_IDLE;
      end
    end else if (ds_byte.valid) begin
      unique case (state_q)
        mca_pkg::ST_IDLE: begin
        end
        mca_pkg::ST_REF_HI: begin
          // three top bits of reference dropped
          ref_d[12:8] = ds_byte.data[4:0];
          state_d = mca_pkg::ST_REF_LO;
        end
        mca_pkg::ST_REF_LO: begin
          ref_d[7:0] = ds_byte.data;
          state_d = res_en_q ? mca_pkg::ST_FB_CNT : mca_pkg::ST_EN_HI;
        end
        mca_pkg::ST_FB_CNT: begin
          cnt_d = ds_byte.data;
          if (ds_byte.data != 8'h00) begin
            state_d = mca_pkg::ST_FB_OFS;
          end else begin
            state_d = grant_en_q ? mca_pkg::ST_EN_HI : mca_pkg::ST_IDLE;
          end
        end
        mca_pkg::ST_FB_OFS: begin
          grp_slot_d = ofs_slot;
          ms_idx_d = 2'h0;
          state_d = mca_pkg::ST_FB_CODE;
        end
        mca_pkg::ST_FB_CODE: begin
          ms_idx_d = ms_idx_q + 2'h1;
          if (mine_q && used_q && grp_slot_q == used_slot_q && ms_idx_q == used_ms_q) begin
            if (ds_byte.data == mca_pkg::CODE_SUCCESS) begin
              used_d = 1'b0;
              pending_d = req_new;
              entered_d = 1'b0;
              done_d = 1'b1;
            end else if (ds_byte.data != mca_pkg::CODE_IDLE) begin
              used_d = 1'b0;
              col_d = 1'b1;
              col_cid_d = ds_byte.data;
            end else begin
              used_d = 1'b0;
            end
          end
          if (ms_idx_q == mca_pkg::MINISLOTS_PER_GROUP - 2'h1) begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
              state_d = grant_en_q ? mca_pkg::ST_EN_HI : mca_pkg::ST_IDLE;
            end else begin
              state_d = mca_pkg::ST_FB_OFS;
            end
          end
        end
        mca_pkg::ST_EN_HI: begin
          stack_d = ds_byte.data[mca_pkg::ENTRY_STACK_BIT-8];
          spread_hi_d = {ds_byte.data[5:0], 8'h00};
          state_d = mca_pkg::ST_EN_LO;
        end
        mca_pkg::ST_EN_LO: begin
          // fresh draw each set of entry minislots
          draw_d = scaled[27:14];
          spread_hi_d = {spread_hi_q[13:8], ds_byte.data};
          zero_idx_d = 15'h0000;
          state_d = mca_pkg::ST_AL_CNT;
        end
        mca_pkg::ST_AL_CNT: begin
          cnt_d = ds_byte.data;
          state_d = (ds_byte.data != 8'h00) ? mca_pkg::ST_AL_OFS : mca_pkg::ST_IDLE;
        end
        mca_pkg::ST_AL_OFS: begin
          grp_slot_d = ofs_slot;
          state_d = mca_pkg::ST_AL_CN;
        end
        mca_pkg::ST_AL_CN: begin
          if (mine_q && pending_q && !used_q) begin
            if (entered_q) begin
              // tree phase: only our own collision id
              if (ds_byte.data == own_cid) begin
                tx_d = '{valid: 1'b1, slot: grp_slot_q, minislot: rnd_ms};
              end
            end else if (stack_q || ds_byte.data == mca_pkg::CID_ENTRY) begin
              // entry groups; draw picks the minislot
              if (draw_q >= zero_idx_q[13:0] && draw_rel < 15'h0003 && !zero_idx_q[14]) begin
                tx_d = '{valid: 1'b1, slot: grp_slot_q, minislot: draw_rel[1:0]};
                entered_d = 1'b1;
              end
              zero_idx_d = zero_idx_q + 15'h0003;
            end
          end
          if (tx_d.valid) begin
            used_d = 1'b1;
            used_slot_d = tx_d.slot;
            used_ms_d = tx_d.minislot;
          end
          cnt_d = cnt_q - 8'h01;
          state_d = (cnt_q == 8'h01) ? mca_pkg::ST_IDLE : mca_pkg::ST_AL_OFS;
        end
        default: begin
          state_d = mca_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // status request after grant time-out; tag then count
  always_comb begin
    tmo_d = tmo_q;
    stat_d = '0;
    if (!grant_pending || grant_seen) begin
      tmo_d = 32'h0000_0000;
    end else if (tmo_q == 32'(GRANT_TIMEOUT_CYCLES - 1)) begin
      tmo_d = 32'h0000_0000;
      stat_d = '{valid: 1'b1, tag: connection_tag, remaining: remaining_slots};
    end else begin
      tmo_d = tmo_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= mca_pkg::ST_IDLE;
      mine_q <= 1'b0;
      res_en_q <= 1'b0;
      grant_en_q <= 1'b0;
      ref_q <= '0;
      cnt_q <= 8'h00;
      grp_slot_q <= '0;
      ms_idx_q <= 2'h0;
      stack_q <= 1'b0;
      spread_hi_q <= '0;
      pending_q <= 1'b0;
      entered_q <= 1'b0;
      used_q <= 1'b0;
      used_slot_q <= '0;
      used_ms_q <= 2'h0;
      draw_q <= '0;
      zero_idx_q <= 15'h0000;
      tx_q <= '0;
      done_q <= 1'b0;
      col_q <= 1'b0;
      col_cid_q <= 8'h00;
      tmo_q <= 32'h0000_0000;
      stat_q <= '0;
    end else begin
      state_q <= state_d;
      mine_q <= mine_d;
      res_en_q <= res_en_d;
      grant_en_q <= grant_en_d;
      ref_q <= ref_d;
      cnt_q <= cnt_d;
      grp_slot_q <= grp_slot_d;
      ms_idx_q <= ms_idx_d;
      stack_q <= stack_d;
      spread_hi_q <= spread_hi_d;
      pending_q <= pending_d;
      entered_q <= entered_d;
      used_q <= used_d;
      used_slot_q <= used_slot_d;
      used_ms_q <= used_ms_d;
      draw_q <= draw_d;
      zero_idx_q <= zero_idx_d;
      tx_q <= tx_d;
      done_q <= done_d;
      col_q <= col_d;
      col_cid_q <= col_cid_d;
      tmo_q <= tmo_d;
      stat_q <= stat_d;
    end
  end

  assign tx_req = tx_q;
  assign contending = entered_q;
  assign contend_done = done_q;
  assign collision_seen = col_q;
  assign collision_cid = col_cid_q;
  assign status_req = stat_q;

endmodule

// ===== sim/mca_assertions.sv
`timescale 1ns/1ps
module mca_assertions #(
  parameter int GRANT_TIMEOUT_CYCLES = mca_pkg::GRANT_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // watched inputs
  input wire mca_pkg::mca_byte_t ds_byte,
  input wire logic grant_pending,
  input wire logic grant_seen,
  input wire logic [15:0] connection_tag,
  input wire logic [7:0] remaining_slots,
  // watched outputs
  input wire mca_pkg::mca_tx_t tx_req,
  input wire logic contending,
  input wire logic contend_done,
  input wire logic collision_seen,
  input wire logic [7:0] collision_cid,
  input wire mca_pkg::mca_status_t status_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // pending run length
  // ****************************************
  int unsigned run_q;
  int unsigned run_d;
  always_comb begin
    run_d = run_q;
    if (!grant_pending || grant_seen || status_req.valid) run_d = 0;
    else if (run_q < GRANT_TIMEOUT_CYCLES) run_d = run_q + 1;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) run_q <= 0;
    else run_q <= run_d;
  end

  // ****************************************
  // properties
  // ****************************************
  sequence s_byte_in;
    $past(ds_byte.valid);
  endsequence
  sequence s_fe_in;
    s_byte_in ##0 $past(ds_byte.data) == 8'hFE;
  endsequence

  status_timer_a: assert property (
    status_req.valid |-> run_q >= GRANT_TIMEOUT_CYCLES - 1)
    else $error("status request before time-out");
  // tag and count are the values the design sampled one edge earlier
  status_fields_a: assert property (status_req.valid |->
    status_req.tag == $past(connection_tag) && status_req.remaining == $past(remaining_slots))
    else $error("status request fields wrong");
  status_pulse_a: assert property (status_req.valid |=> !status_req.valid)
    else $error("status request longer than one cycle");
  tx_cause_a: assert property (tx_req.valid |-> s_byte_in)
    else $error("transmit without a decisive byte");
  tx_minislot_a: assert property (tx_req.valid |-> tx_req.minislot < 2'h3)
    else $error("transmit minislot out of group");
  done_cause_a: assert property (contend_done |-> s_fe_in ##0 $past(contending))
    else $error("completion without success code");
  collision_code_a: assert property (collision_seen |-> s_byte_in ##0
    (collision_cid == $past(ds_byte.data) && collision_cid < 8'hFE))
    else $error("collision report wrong");
  contend_end_a: assert property ($fell(contending) |-> contend_done)
    else $error("contention ended without success");
endmodule

bind mca_top mca_assertions #(.GRANT_TIMEOUT_CYCLES(GRANT_TIMEOUT_CYCLES)) chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .ds_byte(ds_byte), .grant_pending(grant_pending),
  .grant_seen(grant_seen), .connection_tag(connection_tag), .remaining_slots(remaining_slots),
  .tx_req(tx_req), .contending(contending), .contend_done(contend_done),
  .collision_seen(collision_seen), .collision_cid(collision_cid), .status_req(status_req));

// ===== sim/mca_head_end.sv
`timescale 1ns/1ps
module mca_head_end (
  // clock
  input wire logic clk_sys,
  // link to the terminal
  output mca_pkg::mca_byte_t ds_byte,
  input wire mca_pkg::mca_status_t status_req,
  output logic grant_seen
);
  int slow = 0;
  initial begin
    ds_byte = '0;
    grant_seen = 1'b0;
  end

  task automatic put(input logic s, input logic [7:0] d);
    @(posedge clk_sys);
    ds_byte <= {s, 1'b1, d};
  endtask

  // one channel iteration, back to back bytes
  task automatic iter(input logic [2:0] ch, input logic [15:0] rf, input logic fb,
    input logic [7:0] fo, input logic [23:0] codes, input logic al,
    input logic [15:0] en, input logic [7:0] ao, input logic [7:0] cn);
    put(1'b1, {ch, fb, al, 3'h0});
    put(1'b0, rf[15:8]);
    put(1'b0, rf[7:0]);
    if (fb) begin
      put(1'b0, 8'h01);
      put(1'b0, fo);
      put(1'b0, codes[23:16]);
      put(1'b0, codes[15:8]);
      put(1'b0, codes[7:0]);
    end
    if (al) begin
      put(1'b0, en[15:8]);
      put(1'b0, en[7:0]);
      put(1'b0, 8'h01);
      put(1'b0, ao);
      put(1'b0, cn);
    end
    @(posedge clk_sys);
    ds_byte <= '0;
  endtask

  // no calibration path: the terminal has no power or timing pins
  always @(posedge clk_sys) begin
    if (status_req.valid) begin
      repeat (slow) @(posedge clk_sys);
      grant_seen <= 1'b1;
      @(posedge clk_sys);
      grant_seen <= 1'b0;
    end
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_new = 1'b0;
  logic grant_pending = 1'b0;
  logic [2:0] my_channel = 3'h2;
  logic [7:0] own_cid = 8'h00;
  logic [15:0] connection_tag = 16'h0000;
  logic [7:0] remaining_slots = 8'h00;
  logic grant_seen;
  mca_pkg::mca_byte_t ds_byte;
  mca_pkg::mca_tx_t tx_req, tx_last;
  mca_pkg::mca_status_t status_req, st_last;
  logic contending, contend_done, collision_seen;
  logic [7:0] collision_cid;
  int compares = 0;
  int failures = 0;
  int seed = 60213;
  int tx_cnt = 0, done_cnt = 0, coll_cnt = 0, st_cnt = 0;
  int r, n, k, ms;
  logic [15:0] rf;
  logic [7:0] ofs, code, fill, cn;
  localparam int TMO = 8;
  logic [13:0] sp;
  logic [23:0] codes;

  initial forever #5 clk_sys = ~clk_sys;

  mca_top #(.GRANT_TIMEOUT_CYCLES(TMO)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .ds_byte(ds_byte), .my_channel(my_channel), .own_cid(own_cid), .req_new(req_new),
    .grant_pending(grant_pending), .grant_seen(grant_seen), .connection_tag(connection_tag),
    .remaining_slots(remaining_slots), .tx_req(tx_req), .contending(contending),
    .contend_done(contend_done), .collision_seen(collision_seen),
    .collision_cid(collision_cid), .status_req(status_req));
  mca_head_end he (.clk_sys(clk_sys), .ds_byte(ds_byte), .status_req(status_req),
    .grant_seen(grant_seen));

  // ****************************************
  // event capture
  // ****************************************
  // mid-cycle sampling keeps clear of the edge that launches each pulse
  always @(negedge clk_sys) begin
    if (tx_req.valid) begin
      tx_cnt++;
      tx_last = tx_req;
    end
    if (contend_done) done_cnt++;
    if (collision_seen) coll_cnt++;
    if (status_req.valid) begin
      st_cnt++;
      st_last = status_req;
    end
  end

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic pulse_req;
    @(posedge clk_sys);
    req_new <= 1'b1;
    @(posedge clk_sys);
    req_new <= 1'b0;
  endtask

  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    pulse_req();
    he.iter(3'h5, 16'h0000, 1'b0, 8'h00, 24'h0, 1'b1, 16'h0000, 8'h00, 8'h00);
    settle();
    `CHK("tx other channel", 0, tx_cnt)
    for (r = 0; r < 3; r++) begin
      rf = 16'($random(seed));
      ofs = 8'($random(seed));
      sp = 14'({$random(seed)} % 3);
      cn = (r == 2) ? 8'h2A : 8'h00;
      n = tx_cnt;
      he.iter(my_channel, rf, 1'b0, 8'h00, 24'h0, 1'b1, {2'b00, sp}, ofs, cn);
      settle();
      `CHK("tx count", n + 1, tx_cnt)
      `CHK("tx slot", rf[12:0] + ofs, tx_last.slot)
      if (r == 0) `CHK("draw bound", 1'b1, tx_last.minislot <= sp)
      code = (r == 0) ? 8'hFF : (r == 1) ? 8'h2A : 8'hFE;
      fill = (r < 2) ? 8'hFE : 8'h2B;
      codes = {3{fill}};
      ms = tx_last.minislot;
      codes[(2 - ms) * 8 +: 8] = code;
      n = coll_cnt;
      he.iter(my_channel, rf ^ 16'hE000, 1'b1, ofs, codes, 1'b0, 16'h0, 8'h00, 8'h00);
      settle();
      `CHK("done count", (r == 2), done_cnt)
      `CHK("collision count", n + (r == 1), coll_cnt)
      `CHK("contending", (r < 2), contending)
      if (r == 1) `CHK("collision id", 8'h2A, collision_cid)
      if (r == 1) begin
        own_cid <= 8'h2A;
        n = tx_cnt;
        he.iter(my_channel, rf, 1'b0, 8'h00, 24'h0, 1'b1, 16'h0000, ofs, 8'h00);
        settle();
        `CHK("tx foreign cid", n, tx_cnt)
      end
    end
    own_cid <= 8'h55;
    pulse_req();
    n = tx_cnt;
    he.iter(my_channel, 16'h1FFF, 1'b0, 8'h00, 24'h0, 1'b1, 16'h0000, 8'h03, 8'h07);
    settle();
    `CHK("tx nonzero group", n, tx_cnt)
    // both sections in one iteration: feedback first, then allocation
    he.iter(my_channel, 16'h1FFF, 1'b1, 8'h00, 24'hFFFFFF, 1'b1, 16'h8000, 8'h03, 8'h07);
    settle();
    `CHK("stack entry tx", n + 1, tx_cnt)
    `CHK("wrapped slot", 13'h0002, tx_last.slot)
    he.slow = 5;
    connection_tag <= 16'($random(seed));
    remaining_slots <= 8'($random(seed));
    grant_pending <= 1'b1;
    for (k = 0; k < 40 && st_cnt == 0; k++) @(posedge clk_sys);
    `CHK("status wait", TMO + 1, k)
    `CHK("status word", {connection_tag, remaining_slots}, {st_last.tag, st_last.remaining})
    // model answers after its delay, the grant pulse restarts the count
    for (k = 0; k < 60 && st_cnt < 2; k++) @(posedge clk_sys);
    `CHK("status again", 2, st_cnt)
    `CHK("restart wait", TMO + he.slow + 2, k)
    grant_pending <= 1'b0;
    repeat (30) @(posedge clk_sys);
    `CHK("status idle", 2, st_cnt)
    results();
  end
endmodule
